// File: awd_pkg.sv
package awd_pkg;

  // task-file register indices on the plain register port
  localparam logic [3:0] TF_FEAT_ERR = 4'h1;
  localparam logic [3:0] TF_CNT      = 4'h2;
  localparam logic [3:0] TF_SN       = 4'h3;
  localparam logic [3:0] TF_CL       = 4'h4;
  localparam logic [3:0] TF_CH       = 4'h5;
  localparam logic [3:0] TF_DH       = 4'h6;
  localparam logic [3:0] TF_CMD      = 4'h7;
  localparam logic [3:0] TF_CTL      = 4'h8;
  localparam logic [3:0] TF_CFG      = 4'h9;

  // opcodes
  localparam logic [7:0] OP_WDMA       = 8'hca;
  localparam logic [7:0] OP_RETRY_MASK = 8'hfe;
  localparam logic [7:0] OP_WDMA_EXT   = 8'h35;
  localparam logic [7:0] OP_WDMA_FUA   = 8'h3d;

  // field positions
  localparam int unsigned DH_LBA  = 6;
  localparam int unsigned DH_DEV  = 4;
  localparam int unsigned CTL_HOB = 7;
  localparam int unsigned CFG_WCE = 0;

  // error and status masks
  localparam logic [7:0] ERR_NONE = 8'h00;
  localparam logic [7:0] ERR_CRC  = 8'h80;
  localparam logic [7:0] ERR_IDN  = 8'h10;
  localparam logic [7:0] ERR_ABT  = 8'h04;
  localparam logic [7:0] STS_BSY  = 8'h80;
  localparam logic [7:0] STS_RDY  = 8'h40;
  localparam logic [7:0] STS_DSC  = 8'h10;
  localparam logic [7:0] STS_DRQ  = 8'h08;
  localparam logic [7:0] STS_ERR  = 8'h01;

  // sizes and counts
  localparam logic [7:0]  WORD_LAST  = 8'hff;
  localparam logic [7:0]  WORD_FIRST = 8'h00;
  localparam logic [16:0] CNT28_ZERO = 17'h00100;
  localparam logic [16:0] CNT48_ZERO = 17'h10000;
  localparam logic [16:0] CNT_ONE    = 17'h00001;

  // chs geometry used when stepping a non-lba address
  localparam logic [7:0] CHS_SPT        = 8'h3f;
  localparam logic [7:0] CHS_SECT_FIRST = 8'h01;
  localparam logic [3:0] CHS_HEAD_LAST  = 4'hf;

  // reset values and own device select
  localparam logic [7:0] TF_RST  = 8'h00;
  localparam logic       WCE_RST = 1'b0;
  localparam logic       DEV_OWN = 1'b0;

  typedef enum logic [2:0] {S_IDLE, S_XFER, S_MEDIA, S_FLUSH, S_DONE} awd_state_t;

endpackage

// File: awd_addr_trk.sv
`timescale 1ns/1ns
module awd_addr_trk import awd_pkg::*; (
  input  wire logic        clk_sys_i,
  input  wire logic        resetn_i,
  input  wire logic        load_i,
  input  wire logic        lba_i,
  input  wire logic [47:0] start_i,
  input  wire logic [16:0] count_i,
  input  wire logic        step_i,
  output logic      [47:0] cur_o,
  output logic      [47:0] last_o,
  output logic      [16:0] left_o
);

  logic [47:0] cur_r, cur_nxt, last_r, last_nxt;
  logic [16:0] left_r, left_nxt;
  logic        lba_r, lba_nxt;

  // next sector address; chs walks sector, then head, then cylinder
  function automatic logic [47:0] addr_inc(input logic [47:0] a, input logic lba);
    logic [47:0] r;
    r = a + 48'h1;
    if (!lba) begin
      r = a;
      if (a[7:0] >= CHS_SPT) begin
        r[7:0] = CHS_SECT_FIRST;
        if (a[27:24] >= CHS_HEAD_LAST) begin
          r[27:24] = 4'h0;
          r[23:8]  = a[23:8] + 16'h1;
        end else begin
          r[27:24] = a[27:24] + 4'h1;
        end
      end else begin
        r[7:0] = a[7:0] + 8'h1;
      end
    end
    return r;
  endfunction

  always_comb begin
    cur_nxt  = cur_r;
    last_nxt = last_r;
    left_nxt = left_r;
    lba_nxt  = lba_r;
    if (load_i) begin
      cur_nxt  = start_i;
      last_nxt = start_i;
      left_nxt = count_i;
      lba_nxt  = lba_i;
    end else if (step_i) begin
      last_nxt = cur_r;
      cur_nxt  = addr_inc(cur_r, lba_r);
      left_nxt = left_r - CNT_ONE;
    end
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cur_r  <= 48'h0;
      last_r <= 48'h0;
      left_r <= 17'h0;
      lba_r  <= 1'b0;
    end else begin
      cur_r  <= cur_nxt;
      last_r <= last_nxt;
      left_r <= left_nxt;
      lba_r  <= lba_nxt;
    end
  end

  assign cur_o  = cur_r;
  assign last_o = last_r;
  assign left_o = left_r;

endmodule

// File: awd_write_dma.sv
// How it works
// - 28-bit head field: chs head, or address bits 24-27 under lba.
// - retry bit of the 28-bit opcode ignored; both variants identical.
// - 28-bit completion returns untransferred sector count, zero unless error.
// - 28-bit completion returns last sector number, or address bits 0-7.
// - 28-bit completion returns last cylinder, or address bits 8-15 and 16-23.
// - 28-bit completion returns last head, or address bits 24-27.
// - fua opcode commits data to media before status, cache or not.
// - write data arrives as 16-bit words through the data port.
// - each word moves only while the device asserts its dma request.
// - exactly one interrupt per command when transfer ends and status valid.
// - uncorrectable error stops the transfer at the failing sector.
// - opcode 35h decoded as 48-bit dma write.
// - 48-bit count is previous:current; zero means 65,536 sectors.
// - 48-bit start address assembled from current and previous bytes.
// - 48-bit failure returns failing address; hob selects high bytes.
// - 28-bit count of zero means 256 sectors.
// - 28-bit sector number: chs sector, or address bits 0-7 under lba.
`timescale 1ns/1ns
module awd_write_dma import awd_pkg::*; (
  input  wire logic        clk_sys_i,
  input  wire logic        resetn_i,
  input  wire logic [3:0]  reg_addr_i,
  input  wire logic [7:0]  reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic      [7:0]  reg_rdata_o,
  output logic             dmarq_o,
  input  wire logic        dma_wr_i,
  input  wire logic [15:0] dma_data_i,
  input  wire logic        crc_err_i,
  output logic      [15:0] media_data_o,
  output logic             media_valid_o,
  output logic             media_sector_end_o,
  output logic             media_flush_o,
  input  wire logic        media_ok_i,
  input  wire logic        media_unc_i,
  input  wire logic        media_flushed_i,
  output logic             intrq_o
);

  function automatic logic op_is28(input logic [7:0] op);
    return (op & OP_RETRY_MASK) == OP_WDMA;
  endfunction

  function automatic logic op_is48(input logic [7:0] op);
    return (op == OP_WDMA_EXT) || (op == OP_WDMA_FUA);
  endfunction

  // task file: index 0 count, 1 sector number, 2 cylinder low, 3 cylinder high
  logic [7:0]  tf_cur_r  [4];
  logic [7:0]  tf_cur_nxt[4];
  logic [7:0]  tf_prv_r  [4];
  logic [7:0]  tf_prv_nxt[4];
  logic [7:0]  dh_r, dh_nxt, err_r, err_nxt, rdata_r, rdata_nxt, cause_r, cause_nxt;
  logic        hob_r, hob_nxt, wce_r, wce_nxt, sts_err_r, sts_err_nxt, intrq_r, intrq_nxt;
  awd_state_t  st_r, st_nxt;
  logic [7:0]  wcnt_r, wcnt_nxt;
  logic [15:0] mdata_r, mdata_nxt;
  logic        dmarq_r, dmarq_nxt, mvalid_r, mvalid_nxt, mend_r, mend_nxt;
  logic        mflush_r, mflush_nxt, fua_r, fua_nxt, ext_r, ext_nxt;
  logic        trk_load, trk_step, trk_lba, busy, fin, cmd_wr, dev_ok;
  logic [47:0] trk_start, trk_cur, trk_last, rep_addr;
  logic [16:0] trk_count, trk_left;
  logic [15:0] cnt48;
  logic [7:0]  status;

  assign busy   = st_r != S_IDLE;
  assign fin    = st_r == S_DONE;
  assign cmd_wr = reg_wr_i && (reg_addr_i == TF_CMD);
  assign dev_ok = dh_r[DH_DEV] == DEV_OWN;
  assign status = (busy ? STS_BSY : ERR_NONE) | STS_RDY | STS_DSC
                | (dmarq_r ? STS_DRQ : ERR_NONE) | (sts_err_r ? STS_ERR : ERR_NONE);
  assign cnt48  = {tf_prv_r[0], tf_cur_r[0]};

  // start address and count for the command being written
  always_comb begin
    trk_lba   = 1'b1;
    trk_start = {tf_prv_r[3], tf_prv_r[2], tf_prv_r[1],
                 tf_cur_r[3], tf_cur_r[2], tf_cur_r[1]};
    trk_count = (cnt48 == 16'h0) ? CNT48_ZERO : {1'b0, cnt48};
    if (op_is28(reg_wdata_i)) begin
      trk_lba   = dh_r[DH_LBA];
      trk_start = {20'h0, dh_r[3:0], tf_cur_r[3], tf_cur_r[2], tf_cur_r[1]};
      trk_count = (tf_cur_r[0] == TF_RST) ? CNT28_ZERO : {9'h0, tf_cur_r[0]};
    end
  end

  awd_addr_trk u_trk (
    .clk_sys_i (clk_sys_i),
    .resetn_i  (resetn_i),
    .load_i    (trk_load),
    .lba_i     (trk_lba),
    .start_i   (trk_start),
    .count_i   (trk_count),
    .step_i    (trk_step),
    .cur_o     (trk_cur),
    .last_o    (trk_last),
    .left_o    (trk_left)
  );

  // transfer engine
  always_comb begin
    st_nxt     = st_r;
    wcnt_nxt   = wcnt_r;
    mdata_nxt  = mdata_r;
    mvalid_nxt = 1'b0;
    mend_nxt   = 1'b0;
    mflush_nxt = 1'b0;
    fua_nxt    = fua_r;
    ext_nxt    = ext_r;
    cause_nxt  = cause_r;
    trk_load   = 1'b0;
    trk_step   = 1'b0;
    unique case (st_r)
      S_IDLE: begin
        // a command for the other device on the cable is not ours
        if (cmd_wr && dev_ok) begin
          if (op_is28(reg_wdata_i) || op_is48(reg_wdata_i)) begin
            trk_load  = 1'b1;
            ext_nxt   = op_is48(reg_wdata_i);
            fua_nxt   = reg_wdata_i == OP_WDMA_FUA;
            cause_nxt = ERR_NONE;
            wcnt_nxt  = WORD_FIRST;
            st_nxt    = S_XFER;
          end else begin
            cause_nxt = ERR_ABT;
            st_nxt    = S_DONE;
          end
        end
      end
      S_XFER: begin
        if (crc_err_i) begin
          cause_nxt = ERR_CRC | ERR_ABT;
          st_nxt    = S_DONE;
        end else if (dma_wr_i && dmarq_r) begin
          mdata_nxt  = dma_data_i;
          mvalid_nxt = 1'b1;
          wcnt_nxt   = wcnt_r + 8'h1;
          if (wcnt_r == WORD_LAST) begin
            mend_nxt = 1'b1;
            st_nxt   = S_MEDIA;
          end
        end
      end
      S_MEDIA: begin
        if (media_unc_i) begin
          cause_nxt = ERR_IDN;
          st_nxt    = S_DONE;
        end else if (media_ok_i) begin
          trk_step = 1'b1;
          if (trk_left != CNT_ONE) begin
            st_nxt = S_XFER;
          end else if (fua_r || !wce_r) begin
            // the cache may only hold data back when it is on and fua is clear
            mflush_nxt = 1'b1;
            st_nxt     = S_FLUSH;
          end else begin
            st_nxt = S_DONE;
          end
        end
      end
      S_FLUSH: begin
        if (media_unc_i) begin
          cause_nxt = ERR_IDN;
          st_nxt    = S_DONE;
        end else if (media_flushed_i) begin
          st_nxt = S_DONE;
        end
      end
      S_DONE: st_nxt = S_IDLE;
    endcase
    dmarq_nxt = st_nxt == S_XFER;
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_r     <= S_IDLE;
      wcnt_r   <= WORD_FIRST;
      mdata_r  <= 16'h0;
      dmarq_r  <= 1'b0;
      mvalid_r <= 1'b0;
      mend_r   <= 1'b0;
      mflush_r <= 1'b0;
      fua_r    <= 1'b0;
      ext_r    <= 1'b0;
      cause_r  <= ERR_NONE;
    end else begin
      st_r     <= st_nxt;
      wcnt_r   <= wcnt_nxt;
      mdata_r  <= mdata_nxt;
      dmarq_r  <= dmarq_nxt;
      mvalid_r <= mvalid_nxt;
      mend_r   <= mend_nxt;
      mflush_r <= mflush_nxt;
      fua_r    <= fua_nxt;
      ext_r    <= ext_nxt;
      cause_r  <= cause_nxt;
    end
  end

  // failing sector for a failed 48-bit write, otherwise the last one written
  assign rep_addr = (ext_r && cause_r != ERR_NONE) ? trk_cur : trk_last;

  // task file, status and read port
  always_comb begin
    tf_cur_nxt  = tf_cur_r;
    tf_prv_nxt  = tf_prv_r;
    dh_nxt      = dh_r;
    hob_nxt     = hob_r;
    wce_nxt     = wce_r;
    err_nxt     = err_r;
    sts_err_nxt = sts_err_r;
    rdata_nxt   = TF_RST;
    if (reg_wr_i && !busy) begin
      for (int i = 0; i < 4; i++) begin
        if (reg_addr_i == TF_CNT + 4'(i)) begin
          tf_prv_nxt[i] = tf_cur_r[i];
          tf_cur_nxt[i] = reg_wdata_i;
        end
      end
      if (reg_addr_i == TF_DH) begin
        dh_nxt = reg_wdata_i;
      end
      if (reg_addr_i == TF_CFG) begin
        wce_nxt = reg_wdata_i[CFG_WCE];
      end
      if (reg_addr_i == TF_CMD) begin
        err_nxt     = ERR_NONE;
        sts_err_nxt = 1'b0;
      end
      if (reg_addr_i >= TF_CNT && reg_addr_i <= TF_DH) begin
        hob_nxt = 1'b0;
      end
    end
    if (reg_wr_i && reg_addr_i == TF_CTL) begin
      hob_nxt = reg_wdata_i[CTL_HOB];
    end
    if (fin) begin
      err_nxt     = cause_r;
      sts_err_nxt = cause_r != ERR_NONE;
      if (cause_r != ERR_ABT) begin
        tf_cur_nxt[0] = trk_left[7:0];
        tf_prv_nxt[0] = trk_left[15:8];
        tf_cur_nxt[1] = rep_addr[7:0];
        tf_cur_nxt[2] = rep_addr[15:8];
        tf_cur_nxt[3] = rep_addr[23:16];
        if (ext_r) begin
          tf_prv_nxt[1] = rep_addr[31:24];
          tf_prv_nxt[2] = rep_addr[39:32];
          tf_prv_nxt[3] = rep_addr[47:40];
        end else begin
          dh_nxt[3:0] = rep_addr[27:24];
        end
      end
    end
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        TF_FEAT_ERR: rdata_nxt = err_r;
        TF_CNT, TF_SN, TF_CL, TF_CH: begin
          rdata_nxt = hob_r ? tf_prv_r[2'(reg_addr_i - TF_CNT)]
                            : tf_cur_r[2'(reg_addr_i - TF_CNT)];
        end
        TF_DH:   rdata_nxt = dh_r;
        TF_CMD:  rdata_nxt = status;
        TF_CTL:  rdata_nxt = status;
        TF_CFG:  rdata_nxt = {7'h0, wce_r};
        default: rdata_nxt = TF_RST;
      endcase
    end
    // a completion in the same cycle as a status read still raises the line
    intrq_nxt = fin || (intrq_r && !(reg_rd_i && reg_addr_i == TF_CMD) && !cmd_wr);
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      for (int i = 0; i < 4; i++) begin
        tf_cur_r[i] <= TF_RST;
        tf_prv_r[i] <= TF_RST;
      end
      dh_r      <= TF_RST;
      hob_r     <= 1'b0;
      wce_r     <= WCE_RST;
      err_r     <= ERR_NONE;
      sts_err_r <= 1'b0;
      rdata_r   <= TF_RST;
      intrq_r   <= 1'b0;
    end else begin
      tf_cur_r  <= tf_cur_nxt;
      tf_prv_r  <= tf_prv_nxt;
      dh_r      <= dh_nxt;
      hob_r     <= hob_nxt;
      wce_r     <= wce_nxt;
      err_r     <= err_nxt;
      sts_err_r <= sts_err_nxt;
      rdata_r   <= rdata_nxt;
      intrq_r   <= intrq_nxt;
    end
  end

  assign reg_rdata_o        = rdata_r;
  assign dmarq_o            = dmarq_r;
  assign media_data_o       = mdata_r;
  assign media_valid_o      = mvalid_r;
  assign media_sector_end_o = mend_r;
  assign media_flush_o      = mflush_r;
  assign intrq_o            = intrq_r;

  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);

  sequence s_last_ok;
    st_r == S_MEDIA && media_ok_i && !media_unc_i && trk_left == CNT_ONE;
  endsequence

  sequence s_stop;
    st_r == S_DONE && !dmarq_r ##1 st_r == S_IDLE && intrq_r;
  endsequence

  retry_ignored_a: assert property (
    (st_r == S_IDLE && cmd_wr && dev_ok && op_is28(reg_wdata_i)) |=> st_r == S_XFER && dmarq_r)
    else $error("28-bit write opcode not started");
  ext_decode_a: assert property (
    (st_r == S_IDLE && cmd_wr && dev_ok && reg_wdata_i == OP_WDMA_EXT) |=> ext_r && !fua_r)
    else $error("48-bit write opcode not decoded");
  zero256_a: assert property (
    (st_r == S_IDLE && cmd_wr && dev_ok && op_is28(reg_wdata_i) && tf_cur_r[0] == TF_RST)
    |=> trk_left == CNT28_ZERO)
    else $error("28-bit zero count not 256");
  zero65536_a: assert property (
    (st_r == S_IDLE && cmd_wr && dev_ok && op_is48(reg_wdata_i) && cnt48 == 16'h0)
    |=> trk_left == CNT48_ZERO)
    else $error("48-bit zero count not 65536");
  dmarq_gate_a: assert property (
    (media_valid_o && !$past(st_r == S_IDLE)) |-> $past(dmarq_r) && $past(dma_wr_i))
    else $error("word moved without dma request");
  sector_end_a: assert property (
    media_sector_end_o |-> media_valid_o && wcnt_r == WORD_FIRST && st_r == S_MEDIA)
    else $error("sector end not on 256th word");
  fua_flush_a: assert property (
    (s_last_ok and fua_r) |=> media_flush_o && st_r == S_FLUSH && !intrq_r)
    else $error("fua completed before media commit");
  unc_stop_a: assert property (
    (st_r == S_MEDIA && media_unc_i) |=> s_stop)
    else $error("transfer continued after uncorrectable error");
  one_irq_a: assert property (
    $rose(intrq_r) |-> $past(fin) && !busy)
    else $error("interrupt without command completion");
  count_back_a: assert property (
    (fin && !ext_r && cause_r == ERR_NONE) |=> tf_cur_r[0] == 8'h00 && !sts_err_r)
    else $error("remaining count not zero after good write");
  hob_read_a: assert property (
    (reg_rd_i && reg_addr_i == TF_SN && hob_r) |=> reg_rdata_o == $past(tf_prv_r[1]))
    else $error("high-order byte not returned under hob");

endmodule

// File: awd_host_media.sv
`timescale 1ns/1ns
module awd_host_media (
  input  wire logic        clk_sys_i,
  input  wire logic        resetn_i,
  input  wire logic        en_i,
  input  wire logic        slow_i,
  input  wire logic [7:0]  fail_i,
  input  wire logic        dmarq_i,
  input  wire logic        sec_end_i,
  input  wire logic        flush_i,
  output logic             dma_wr_o,
  output logic      [15:0] dma_data_o,
  output logic             ok_o,
  output logic             unc_o,
  output logic             flushed_o
);
  logic [15:0] word_r;
  logic [8:0]  left_r;
  logic [7:0]  sec_r;
  logic [3:0]  mdly_r;
  logic [3:0]  fdly_r;
  logic        odd_r;
  logic [15:0] word_nxt;
  logic [8:0]  left_nxt;
  logic        wr_nxt;
  always_comb begin
    word_nxt = dma_wr_o ? word_r + 16'h0001 : word_r;
    left_nxt = dma_wr_o ? left_r - 9'h001 : left_r;
    // never past one sector: the request only drops after the last word
    wr_nxt = en_i && dmarq_i && (left_nxt != 9'h000) && !(slow_i && odd_r);
  end
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      word_r <= 16'h0000;
      left_r <= 9'h100;
      sec_r <= 8'h00;
      mdly_r <= 4'h0;
      fdly_r <= 4'h0;
      odd_r <= 1'b0;
      dma_wr_o <= 1'b0;
      dma_data_o <= 16'h0000;
      ok_o <= 1'b0;
      unc_o <= 1'b0;
      flushed_o <= 1'b0;
    end else begin
      odd_r <= ~odd_r;
      dma_wr_o <= wr_nxt;
      // released lines toggle so a stale word never looks valid
      dma_data_o <= wr_nxt ? (word_nxt ^ 16'h5a5a) : ~dma_data_o;
      word_r <= en_i ? word_nxt : 16'h0000;
      left_r <= dmarq_i ? left_nxt : 9'h100;
      ok_o <= (mdly_r == 4'h1) && (sec_r != fail_i);
      unc_o <= (mdly_r == 4'h1) && (sec_r == fail_i);
      flushed_o <= (fdly_r == 4'h1);
      if (sec_end_i) begin
        mdly_r <= slow_i ? 4'h6 : 4'h1;
      end else if (mdly_r != 4'h0) begin
        mdly_r <= mdly_r - 4'h1;
      end
      if (flush_i) begin
        fdly_r <= slow_i ? 4'h7 : 4'h1;
      end else if (fdly_r != 4'h0) begin
        fdly_r <= fdly_r - 4'h1;
      end
      if (!en_i) begin
        sec_r <= 8'h00;
      end else if (mdly_r == 4'h1) begin
        sec_r <= sec_r + 8'h01;
      end
    end
  end
endmodule

// File: tb.sv
`timescale 1ns/1ns
module tb;
  import awd_pkg::*;
  typedef struct packed {
    logic [7:0]  op;
    logic        lba;
    logic        wce;
    logic [15:0] cnt;
    logic [47:0] adr;
    logic [7:0]  fail;
    logic [7:0]  err;
    logic [15:0] left;
    logic [47:0] eadr;
    logic [7:0]  sec;
    logic        flush;
  } awd_row_t;
  logic        clk_sys_i = 1'b0;
  logic        resetn_i = 1'b0;
  logic [3:0]  reg_addr_i = 4'h0;
  logic [7:0]  reg_wdata_i = 8'h00;
  logic        reg_wr_i = 1'b0;
  logic        reg_rd_i = 1'b0;
  logic        crc_err_i = 1'b0;
  logic        en = 1'b0;
  logic [7:0]  fail = 8'hff;
  logic [7:0]  reg_rdata_o;
  logic        dmarq_o;
  logic        dma_wr_i;
  logic [15:0] dma_data_i;
  logic [15:0] media_data_o;
  logic        media_valid_o;
  logic        media_sector_end_o;
  logic        media_flush_o;
  logic        media_ok_i;
  logic        media_unc_i;
  logic        media_flushed_i;
  logic        intrq_o;
  logic        irq_q = 1'b0;
  logic [15:0] words = 16'h0000;
  logic [3:0]  irq_cnt = 4'h0;
  logic [3:0]  flush_cnt = 4'h0;
  logic [7:0]  sec_cnt = 8'h00;
  int          error_cnt = 0;
  int          check_count = 0;
  // odd opcodes run with a stalling host and slow media
  awd_row_t rows [8] = '{
    '{8'hca, 1'b1, 1'b0, 16'h0002, 48'h1234567, 8'hff, 8'h00, 16'h0, 48'h1234568, 8'h2, 1'b1},
    '{8'hcb, 1'b1, 1'b0, 16'h0002, 48'h12345ff, 8'hff, 8'h00, 16'h0, 48'h1234600, 8'h2, 1'b1},
    '{8'h35, 1'b1, 1'b0, 16'h0002, 48'haabbccddeeff, 8'hff, 8'h00, 16'h0, 48'haabbccddef00, 8'h2, 1'b1},
    '{8'h3d, 1'b1, 1'b1, 16'h0002, 48'haabbccddeeff, 8'hff, 8'h00, 16'h0, 48'haabbccddef00, 8'h2, 1'b1},
    '{8'h35, 1'b1, 1'b1, 16'h0001, 48'h10, 8'hff, 8'h00, 16'h0, 48'h10, 8'h1, 1'b0},
    '{8'h35, 1'b1, 1'b0, 16'h0000, 48'h0102030405ff, 8'h01, 8'h10, 16'hffff, 48'h010203040600, 8'h2, 1'b0},
    '{8'hca, 1'b1, 1'b0, 16'h0000, 48'h0abcdef, 8'h02, 8'h10, 16'h00fe, 48'h0abcdf0, 8'h3, 1'b0},
    '{8'hca, 1'b0, 1'b0, 16'h0001, 48'h3123405, 8'hff, 8'h00, 16'h0, 48'h3123405, 8'h1, 1'b1}
  };

  always #50 clk_sys_i = ~clk_sys_i;

  awd_write_dma uut (.clk_sys_i, .resetn_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
    .reg_rdata_o, .dmarq_o, .dma_wr_i, .dma_data_i, .crc_err_i, .media_data_o, .media_valid_o,
    .media_sector_end_o, .media_flush_o, .media_ok_i, .media_unc_i, .media_flushed_i, .intrq_o);

  awd_host_media u_host (.clk_sys_i, .resetn_i, .en_i(en), .slow_i(reg_wdata_i[0]),
    .fail_i(fail), .dmarq_i(dmarq_o), .sec_end_i(media_sector_end_o), .flush_i(media_flush_o),
    .dma_wr_o(dma_wr_i), .dma_data_o(dma_data_i), .ok_o(media_ok_i), .unc_o(media_unc_i),
    .flushed_o(media_flushed_i));

  task automatic wrap_up();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk_sys_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b0;
    @(negedge clk_sys_i);
    chk(reg_rdata_o, e);
  endtask

  task automatic wait_irq();
    for (int n = 0; n < 9000 && intrq_o !== 1'b1; n++) begin
      @(negedge clk_sys_i);
    end
    chk(intrq_o, 1'b1);
  endtask

  task automatic run_row(input awd_row_t r);
    logic        ext;
    logic [31:0] pv;
    logic [31:0] cv;
    ext = ~r.op[7];
    pv = {r.adr[47:24], r.cnt[15:8]};
    cv = {r.adr[23:0], r.cnt[7:0]};
    wr(TF_CFG, {7'h00, r.wce});
    fail <= r.fail;
    en <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      if (ext) wr(TF_CNT + 4'(i), pv[8*i +: 8]);
      wr(TF_CNT + 4'(i), cv[8*i +: 8]);
    end
    wr(TF_DH, {1'b1, r.lba, 2'b10, ext ? 4'h0 : r.adr[27:24]});
    wr(TF_CMD, r.op);
    wait_irq();
    rd(TF_CMD, (r.err != 8'h00) ? 8'h51 : 8'h50);
    chk(intrq_o, 1'b0);
    rd(TF_FEAT_ERR, r.err);
    pv = {r.eadr[47:24], r.left[15:8]};
    cv = {r.eadr[23:0], r.left[7:0]};
    for (int i = 0; i < 4; i++) rd(TF_CNT + 4'(i), cv[8*i +: 8]);
    if (!ext) rd(TF_DH, {1'b1, r.lba, 2'b10, r.eadr[27:24]});
    if (ext) wr(TF_CTL, 8'h80);
    for (int i = 0; ext && i < 4; i++) rd(TF_CNT + 4'(i), pv[8*i +: 8]);
    chk(words, {r.sec, 8'h00});
    chk(flush_cnt, r.flush);
    chk(sec_cnt, r.sec);
    chk(irq_cnt, 4'h1);
    wr(TF_CTL, 8'h00);
    en <= 1'b0;
  endtask

  always @(posedge clk_sys_i) begin
    irq_q <= intrq_o;
    if (!en) begin
      words <= 16'h0000;
      irq_cnt <= 4'h0;
      flush_cnt <= 4'h0;
      sec_cnt <= 8'h00;
    end else begin
      if (media_sector_end_o === 1'b1) sec_cnt <= sec_cnt + 8'h01;
      if (intrq_o === 1'b1 && irq_q !== 1'b1) irq_cnt <= irq_cnt + 4'h1;
      if (media_flush_o === 1'b1) flush_cnt <= flush_cnt + 4'h1;
      if (media_valid_o === 1'b1) begin
        words <= words + 16'h0001;
        chk(media_data_o, words ^ 16'h5a5a);
      end
    end
  end

  initial begin
    repeat (30000) @(posedge clk_sys_i);
    error_cnt++;
    wrap_up();
  end

  initial begin
    repeat (6) @(posedge clk_sys_i);
    resetn_i <= 1'b1;
    foreach (rows[k]) run_row(rows[k]);
    wr(TF_CNT, 8'h01);
    wr(TF_DH, 8'hf0);
    wr(TF_CMD, OP_WDMA);
    repeat (3) @(negedge clk_sys_i);
    chk({dmarq_o, intrq_o}, 2'b00);
    wr(TF_DH, 8'he0);
    en <= 1'b1;
    wr(TF_CMD, OP_WDMA);
    for (int n = 0; n < 20 && dmarq_o !== 1'b1; n++) @(negedge clk_sys_i);
    repeat (10) @(posedge clk_sys_i);
    crc_err_i <= 1'b1;
    @(posedge clk_sys_i);
    crc_err_i <= 1'b0;
    wait_irq();
    chk(dmarq_o, 1'b0);
    rd(TF_FEAT_ERR, ERR_CRC | ERR_ABT);
    rd(TF_CMD, 8'h51);
    rd(4'hf, 8'h00);
    en <= 1'b0;
    @(posedge clk_sys_i);
    en <= 1'b1;
    wr(TF_CMD, 8'h20);
    wait_irq();
    rd(TF_FEAT_ERR, ERR_ABT);
    chk(words, 16'h0000);
    // a reset with the interrupt still pending must drop it
    @(posedge clk_sys_i);
    resetn_i <= 1'b0;
    repeat (6) @(posedge clk_sys_i);
    chk({dmarq_o, intrq_o, reg_rdata_o}, 10'h000);
    resetn_i <= 1'b1;
    en <= 1'b0;
    rd(TF_CNT, 8'h00);
    rd(TF_CMD, 8'h50);
    wrap_up();
  end
endmodule
